// >>> rtl/sbs_sram_ctrl.sv
`timescale 1ns/1ps
module sbs_sram_ctrl #(
    parameter int DEPTH = sbs_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // command stream
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic cmd_advance,
    input wire logic [sbs_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [sbs_pkg::LANES-1:0] cmd_lanes_n,
    input wire logic [sbs_pkg::DATA_W-1:0] cmd_data,
    input wire logic [sbs_pkg::PAR_W-1:0] cmd_parity,
    // port control
    input wire logic hold_req,
    input wire logic sleep_req,
    // read return
    output logic rd_valid_q,
    output logic [sbs_pkg::DATA_W-1:0] rd_data_q,
    output logic [sbs_pkg::PAR_W-1:0] rd_parity_q,
    // memory bus, controller end
    sbs_bus_if.ctrl bus
);
    // ----------------------------------------------------------------
    // command buffer
    // ----------------------------------------------------------------
    localparam int AW = sbs_pkg::ADDR_W;
    localparam int PW = sbs_pkg::PAR_W;
    localparam int DW = sbs_pkg::DATA_W;
    localparam int CW = 2 + AW + sbs_pkg::LANES + DW + PW;

    logic f_valid;
    logic f_ready;
    logic [CW-1:0] f_data;
    logic take;
    logic qual_n_q;
    logic sleep_q;
    logic sel_q;
    logic adv_q;
    logic write_n_q;
    logic gate_n_q;
    logic [AW-1:0] addr_q;
    logic [sbs_pkg::LANES-1:0] lanes_q;
    logic [DW-1:0] wdata_q;
    logic [PW-1:0] wpar_q;
    logic oe_q;
    logic [DW-1:0] dq_q;
    logic [PW-1:0] par_q;
    sbs_pkg::sbs_op_t bus_op_q;
    sbs_pkg::sbs_op_t data_op_q;

    // a stalled port stops popping, so the buffer fills and cmd_ready drops
    sbs_fifo #(.WIDTH(CW), .DEPTH(DEPTH)) u_cmd_fifo (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data({cmd_write, cmd_advance, cmd_addr, cmd_lanes_n, cmd_data, cmd_parity}),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    // the device acts only on edges where the qualifier is low
    assign take = !qual_n_q && !sleep_q;
    assign f_ready = take;

    // ----------------------------------------------------------------
    // bus drivers
    // ----------------------------------------------------------------
    assign bus.addr_high = addr_q[AW-1:2];
    assign bus.burst_seed_bit1 = addr_q[1];
    assign bus.burst_seed_bit0 = addr_q[0];
    assign bus.byte_lane_write_n = lanes_q;
    assign bus.write_n = write_n_q;
    assign bus.advance_or_load = adv_q;
    assign bus.clock_qualifier_n = qual_n_q;
    // one select pattern selects, its inverse deselects
    assign bus.select_first_n = !sel_q;
    assign bus.select_second = sel_q;
    assign bus.select_third_n = !sel_q;
    assign bus.output_gate_n = gate_n_q;
    assign bus.sleep_request = sleep_q;
    assign bus.ctrl_dq = dq_q;
    assign bus.ctrl_parity = par_q;
    assign bus.ctrl_dq_oe = oe_q;

    // qualifier high stretches the cycle; select stays as it is
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            qual_n_q <= 1'b1;
            sleep_q <= 1'b0;
        end else begin
            qual_n_q <= hold_req;
            sleep_q <= sleep_req;
        end
    end

    // ----------------------------------------------------------------
    // command stage
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sel_q <= 1'b0;
            adv_q <= 1'b0;
            write_n_q <= 1'b1;
            addr_q <= '0;
            lanes_q <= sbs_pkg::RST_LANES_N;
            wdata_q <= '0;
            wpar_q <= '0;
            bus_op_q <= sbs_pkg::SBS_OP_IDLE;
        end else if (sleep_q) begin
            sel_q <= 1'b0;
            adv_q <= 1'b0;
            bus_op_q <= sbs_pkg::SBS_OP_IDLE;
        end else if (take && f_valid) begin
            sel_q <= 1'b1;
            addr_q <= f_data[CW-3 -: AW];
            lanes_q <= f_data[DW+PW +: sbs_pkg::LANES];
            wdata_q <= f_data[PW +: DW];
            wpar_q <= f_data[PW-1:0];
            // strobe low on a load asks for a write
            write_n_q <= !f_data[CW-1];
            // after a deselect the next access is always a load
            if (f_data[CW-2] && (bus_op_q != sbs_pkg::SBS_OP_IDLE)) begin
                adv_q <= 1'b1;
            end else begin
                adv_q <= 1'b0;
                bus_op_q <= f_data[CW-1] ? sbs_pkg::SBS_OP_WRITE : sbs_pkg::SBS_OP_READ;
            end
        end else if (take) begin
            sel_q <= 1'b0;
            adv_q <= 1'b0;
            write_n_q <= 1'b1;
            bus_op_q <= sbs_pkg::SBS_OP_IDLE;
        end
    end

    // ----------------------------------------------------------------
    // data stage
    // ----------------------------------------------------------------
    // write data follows its command by one qualified edge; gate only low
    // in read data cycles so both ends never drive together
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            data_op_q <= sbs_pkg::SBS_OP_IDLE;
            oe_q <= 1'b0;
            dq_q <= '0;
            par_q <= '0;
            gate_n_q <= 1'b1;
        end else if (sleep_q) begin
            data_op_q <= sbs_pkg::SBS_OP_IDLE;
            oe_q <= 1'b0;
            gate_n_q <= 1'b1;
        end else if (take) begin
            data_op_q <= bus_op_q;
            oe_q <= (bus_op_q == sbs_pkg::SBS_OP_WRITE);
            dq_q <= wdata_q;
            par_q <= wpar_q;
            gate_n_q <= (bus_op_q != sbs_pkg::SBS_OP_READ);
        end
    end

    // lanes left high keep their old contents on the device
    // read data is taken at the edge that closes its data cycle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_valid_q <= 1'b0;
            rd_data_q <= '0;
            rd_parity_q <= '0;
        end else begin
            rd_valid_q <= take && (data_op_q == sbs_pkg::SBS_OP_READ);
            if (take && (data_op_q == sbs_pkg::SBS_OP_READ)) begin
                rd_data_q <= bus.dq_level;
                rd_parity_q <= bus.parity_lanes;
            end
        end
    end
endmodule

// >>> common/sbs_pkg.sv
package sbs_pkg;

    // ----------------------------------------------------------------
    // widths of the memory port
    // ----------------------------------------------------------------
    localparam int ADDR_W = 19;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int DATA_W = LANES * LANE_W;
    localparam int PAR_W = LANES;
    localparam int BURST_W = 2;

    // ----------------------------------------------------------------
    // buffering and reset values
    // ----------------------------------------------------------------
    localparam int FIFO_DEPTH = 8;
    localparam logic [LANES-1:0] RST_LANES_N = 4'hf;
    localparam logic RST_STRAP = 1'b1;
    localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

    // operation held by either end for the cycle after a qualified edge
    typedef enum logic [1:0] {
        SBS_OP_IDLE = 2'b00,
        SBS_OP_READ = 2'b01,
        SBS_OP_WRITE = 2'b10
    } sbs_op_t;

endpackage

// >>> common/sbs_bus_if.sv
`timescale 1ns/1ps
interface sbs_bus_if #(
    parameter int ADDR_W = sbs_pkg::ADDR_W
);
    // address: upper bits plus the two burst seed bits
    logic [ADDR_W-3:0] addr_high;
    logic burst_seed_bit1;
    logic burst_seed_bit0;
    // control, all sampled on the rising edge except gate and sleep
    logic [sbs_pkg::LANES-1:0] byte_lane_write_n;
    logic write_n;
    logic advance_or_load;
    logic clock_qualifier_n;
    logic select_first_n;
    logic select_second;
    logic select_third_n;
    logic output_gate_n;
    logic sleep_request;
    // board strap, driven by the bench
    logic burst_order_strap;
    // two-way data and parity lanes, split per driver
    logic [sbs_pkg::DATA_W-1:0] ctrl_dq;
    logic [sbs_pkg::PAR_W-1:0] ctrl_parity;
    logic ctrl_dq_oe;
    logic [sbs_pkg::DATA_W-1:0] dev_dq;
    logic [sbs_pkg::PAR_W-1:0] dev_parity;
    logic dev_dq_oe;
    // resolved wire levels; a floating bus reads as zero
    logic [sbs_pkg::DATA_W-1:0] dq_level;
    logic [sbs_pkg::PAR_W-1:0] parity_lanes;
    logic sleep_seen;
    logic strap_interleaved;

    assign dq_level = dev_dq_oe ? dev_dq : (ctrl_dq_oe ? ctrl_dq : '0);
    assign parity_lanes = dev_dq_oe ? dev_parity : (ctrl_dq_oe ? ctrl_parity : '0);
    // pull-down on sleep: only a firm high requests sleep
    assign sleep_seen = (sleep_request === 1'b1);
    // an open strap reads as interleaved
    assign strap_interleaved = (burst_order_strap !== 1'b0);

    modport ctrl (
        output addr_high, burst_seed_bit1, burst_seed_bit0, byte_lane_write_n,
        output write_n, advance_or_load, clock_qualifier_n,
        output select_first_n, select_second, select_third_n,
        output output_gate_n, sleep_request, ctrl_dq, ctrl_parity, ctrl_dq_oe,
        input dq_level, parity_lanes
    );

    modport dev (
        input addr_high, burst_seed_bit1, burst_seed_bit0, byte_lane_write_n,
        input write_n, advance_or_load, clock_qualifier_n,
        input select_first_n, select_second, select_third_n,
        input output_gate_n, sleep_seen, strap_interleaved,
        input dq_level, parity_lanes,
        output dev_dq, dev_parity, dev_dq_oe
    );
endinterface

// >>> rtl/sbs_fifo.sv
`timescale 1ns/1ps
module sbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = sbs_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // flags come straight from the count, so full and empty are exact
    assign in_ready = (cnt_q != FULL);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage, not reset
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // pointers wrap at the last entry so any depth works
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == LAST) ? '0 : AW'(wr_q + 1'b1);
            end
            if (pop) begin
                rd_q <= (rd_q == LAST) ? '0 : AW'(rd_q + 1'b1);
            end
            if (push && !pop) begin
                cnt_q <= (AW+1)'(cnt_q + 1'b1);
            end else if (pop && !push) begin
                cnt_q <= (AW+1)'(cnt_q - 1'b1);
            end
        end
    end
endmodule

// >>> rtl/sbs_sram_dev.sv
`timescale 1ns/1ps
// Overview of operation
// - capture address; low two bits seed burst
// - lane written when lane select and strobe low
// - write strobe low starts write, qualified edges only
// - advance high steps burst counter, keeps address
// - advance low loads a new access address
// - controller loads fresh address after any deselect
// - edges ignored while clock qualifier is high
// - qualifier high stretches cycle, never deselects
// - selected only with first, third low, second high
// - output gate low lets data pins drive
// - data floats in write data, deselected cycles
// - sleep input high idles, keeps memory contents
// - sleep pulled down; open means normal operation
// - read data flows through from previous edge
// - strap low linear, high or open interleaved
// - write data captured on the rising edge
module sbs_sram_dev #(
    parameter int ADDR_W = sbs_pkg::ADDR_W
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // memory bus, device end
    sbs_bus_if.dev bus,
    // status
    output logic sleeping_q,
    output logic selected_q
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    localparam int LW = sbs_pkg::LANE_W + 1;
    localparam int LANE_W = sbs_pkg::LANE_W;

    logic take;
    logic sel;
    logic load;
    logic step;
    sbs_pkg::sbs_op_t op_q;
    sbs_pkg::sbs_op_t op_d;
    logic [ADDR_W-3:0] high_q;
    logic [sbs_pkg::BURST_W-1:0] base_q;
    logic [sbs_pkg::BURST_W-1:0] cnt_q;
    logic [sbs_pkg::BURST_W-1:0] low;
    logic [sbs_pkg::LANES-1:0] lanes_n_q;
    logic strap_q;
    logic [ADDR_W-1:0] cur_addr;
    logic [sbs_pkg::DATA_W-1:0] rd_data;
    logic [sbs_pkg::PAR_W-1:0] rd_par;

    // ----------------------------------------------------------------
    // edge qualification and decode
    // ----------------------------------------------------------------
    // qualified edge only
    // sleep blocks all edges; sleep is treated as synchronous here
    // the pull-down is resolved on the wire, open reads as awake
    assign take = !bus.clock_qualifier_n && !bus.sleep_seen;

    // select decode on every qualified edge
    assign sel = !bus.select_first_n && bus.select_second && !bus.select_third_n;

    assign load = take && sel && !bus.advance_or_load;

    // advance only continues a live access
    // advance straight after a deselect is dropped, not continued
    assign step = take && sel && bus.advance_or_load && (op_q != sbs_pkg::SBS_OP_IDLE);

    // next operation for the cycle after this edge
    always_comb begin
        op_d = op_q;
        if (!sel) begin
            op_d = sbs_pkg::SBS_OP_IDLE;
        end else if (!bus.advance_or_load) begin
            // strobe low at load starts a write
            op_d = bus.write_n ? sbs_pkg::SBS_OP_READ : sbs_pkg::SBS_OP_WRITE;
        end else if (op_q == sbs_pkg::SBS_OP_IDLE) begin
            op_d = sbs_pkg::SBS_OP_IDLE;
        end
    end

    // ----------------------------------------------------------------
    // operation state
    // ----------------------------------------------------------------
    // without a qualified edge everything holds; select is kept
    // sleep drops the access so the controller must reload
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            op_q <= sbs_pkg::SBS_OP_IDLE;
        end else if (bus.sleep_seen) begin
            op_q <= sbs_pkg::SBS_OP_IDLE;
        end else if (take) begin
            op_q <= op_d;
        end
    end

    // ----------------------------------------------------------------
    // address and burst counter
    // ----------------------------------------------------------------
    // address captured, low bits seed the burst
    // counter steps modulo four, upper bits untouched
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            high_q <= '0;
            base_q <= '0;
            cnt_q <= '0;
        end else if (load) begin
            high_q <= bus.addr_high;
            base_q <= {bus.burst_seed_bit1, bus.burst_seed_bit0};
            cnt_q <= '0;
        end else if (step) begin
            cnt_q <= sbs_pkg::BURST_W'(cnt_q + sbs_pkg::BURST_STEP);
        end
    end

    // strap picks the order of the burst
    // xor walks the interleaved order, add the linear one
    always_comb begin
        low = strap_q ? (base_q ^ cnt_q) : sbs_pkg::BURST_W'(base_q + cnt_q);
    end
    assign cur_addr = {high_q, low};

    // strap is static; sampling it every edge also covers reset release
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            strap_q <= sbs_pkg::RST_STRAP;
        end else begin
            strap_q <= bus.strap_interleaved;
        end
    end

    // lane selects taken each qualified edge, so burst beats
    // may change their byte mask
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            lanes_n_q <= sbs_pkg::RST_LANES_N;
        end else if (take) begin
            lanes_n_q <= bus.byte_lane_write_n;
        end
    end

    // ----------------------------------------------------------------
    // storage, one array per lane
    // ----------------------------------------------------------------
    // write data lands one qualified edge after its command, so a read
    // issued at that same edge already sees the new contents
    for (genvar l = 0; l < sbs_pkg::LANES; l++) begin : g_lane
        logic [LW-1:0] mem [2**ADDR_W];

        // data and parity taken from the lanes at the rising edge
        // only lanes whose select was low are written
        always_ff @(posedge clk_sys) begin
            if (take && (op_q == sbs_pkg::SBS_OP_WRITE) && !lanes_n_q[l]) begin
                mem[cur_addr] <= {bus.parity_lanes[l], bus.dq_level[l*LANE_W +: LANE_W]};
            end
        end

        // flow-through: location of the last edge read without a register
        assign rd_data[l*LANE_W +: LANE_W] = mem[cur_addr][LANE_W-1:0];
        assign rd_par[l] = mem[cur_addr][LANE_W];
    end

    // ----------------------------------------------------------------
    // output drivers
    // ----------------------------------------------------------------
    assign bus.dev_dq = rd_data;
    assign bus.dev_parity = rd_par;

    // gate is asynchronous and acts at once
    // write data and deselected cycles never drive, whatever the gate
    assign bus.dev_dq_oe = (op_q == sbs_pkg::SBS_OP_READ) && !bus.output_gate_n
        && !bus.sleep_seen;

    // ----------------------------------------------------------------
    // status
    // ----------------------------------------------------------------
    // status mirrors, one edge behind the bus
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sleeping_q <= 1'b0;
            selected_q <= 1'b0;
        end else begin
            sleeping_q <= bus.sleep_seen;
            if (bus.sleep_seen) begin
                selected_q <= 1'b0;
            end else if (take) begin
                selected_q <= (op_d != sbs_pkg::SBS_OP_IDLE);
            end
        end
    end
endmodule

// >>> testbench/sbs_bus_properties.sv
`timescale 1ns/1ps
module sbs_bus_properties (
    // clock and reset
    input logic clk_sys,
    input logic sys_rst,
    // bus control as seen on the wire
    input logic clock_qualifier_n,
    input logic select_first_n,
    input logic select_second,
    input logic select_third_n,
    input logic write_n,
    input logic advance_or_load,
    input logic output_gate_n,
    input logic sleep_seen,
    // data lanes
    input logic dev_dq_oe,
    input logic ctrl_dq_oe,
    input logic [sbs_pkg::DATA_W-1:0] dq_level
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    logic take;
    logic sel;
    logic desel_q;

    // qualified edge and select decode
    assign take = !clock_qualifier_n && !sleep_seen;
    assign sel = !select_first_n && select_second && !select_third_n;

    // remembers a deselect until the next selected edge; reset counts as deselected
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            desel_q <= 1'b1;
        end else if (take) begin
            desel_q <= !sel;
        end
    end

    sequence s_read_load;
        take && sel && !advance_or_load && write_n ##1 !output_gate_n && !sleep_seen;
    endsequence
    sequence s_read_held;
        dev_dq_oe && clock_qualifier_n && !sleep_seen;
    endsequence

    property p_gate_drive;
        dev_dq_oe |-> !output_gate_n && !sleep_seen;
    endproperty
    property p_ctrl_gate;
        ctrl_dq_oe |-> output_gate_n;
    endproperty
    property p_write_float;
        take && sel && !advance_or_load && !write_n |=> !dev_dq_oe;
    endproperty
    property p_desel;
        take && !sel |=> !dev_dq_oe;
    endproperty
    property p_read_flow;
        s_read_load |-> dev_dq_oe;
    endproperty
    property p_stretch;
        s_read_held |=> output_gate_n || sleep_seen || (dev_dq_oe && $stable(dq_level));
    endproperty
    property p_advance_keep;
        dev_dq_oe && take && sel && advance_or_load |=> output_gate_n || sleep_seen || dev_dq_oe;
    endproperty
    property p_fresh_load;
        take && sel && desel_q |-> !advance_or_load;
    endproperty
    property p_sleep_float;
        sleep_seen |=> !dev_dq_oe;
    endproperty

    a_gate_drive: assert property (p_gate_drive) else $error("data driven without gate");
    a_ctrl_gate: assert property (p_ctrl_gate) else $error("controller drives with gate low");
    a_write_float: assert property (p_write_float) else $error("device drove in write data");
    a_desel: assert property (p_desel) else $error("device drove while deselected");
    a_read_flow: assert property (p_read_flow) else $error("read data not presented");
    a_stretch: assert property (p_stretch) else $error("stretched read data changed");
    a_advance_keep: assert property (p_advance_keep) else $error("advance lost read");
    a_fresh_load: assert property (p_fresh_load) else $error("advance after deselect");
    a_sleep_float: assert property (p_sleep_float) else $error("device drove after sleep");
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic cmd_advance = 1'b0;
    logic [18:0] cmd_addr = '0;
    logic [3:0] cmd_lanes_n = 4'hf;
    logic [31:0] cmd_data = '0;
    logic [3:0] cmd_parity = '0;
    logic hold_req = 1'b0;
    logic sleep_req = 1'b0;
    logic cmd_ready, rd_valid_q;
    logic [31:0] rd_data_q;
    logic [3:0] rd_parity_q;
    logic [35:0] mem_m [logic [18:0]];
    logic [35:0] exp_q [$];
    logic [15:0] rnd = 16'h00dc;
    logic [18:0] base;
    int fails = 0;
    int comparisons = 0;
    int cyc = 0;
    int cnt = 0;
    int n;
    bit rd_op, rnd_ctl, ok;
    logic sleeping, selected;

    sbs_bus_if u_bus ();
    sbs_sram_ctrl u_sbs_sram_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_advance(cmd_advance),
        .cmd_addr(cmd_addr), .cmd_lanes_n(cmd_lanes_n), .cmd_data(cmd_data),
        .cmd_parity(cmd_parity), .hold_req(hold_req), .sleep_req(sleep_req),
        .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q), .rd_parity_q(rd_parity_q), .bus(u_bus));
    sbs_sram_dev u_sbs_sram_dev (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(u_bus),
        .sleeping_q(sleeping), .selected_q(selected));
    sbs_bus_properties u_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .clock_qualifier_n(u_bus.clock_qualifier_n), .select_first_n(u_bus.select_first_n),
        .select_second(u_bus.select_second), .select_third_n(u_bus.select_third_n),
        .write_n(u_bus.write_n), .advance_or_load(u_bus.advance_or_load),
        .output_gate_n(u_bus.output_gate_n), .sleep_seen(u_bus.sleep_seen),
        .dev_dq_oe(u_bus.dev_dq_oe), .ctrl_dq_oe(u_bus.ctrl_dq_oe), .dq_level(u_bus.dq_level));

    always #12.5 clk_sys = ~clk_sys;

    function automatic logic [15:0] lfsr(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    function automatic logic [18:0] burst_addr(logic [18:0] b, int c, logic il);
        burst_addr = b;
        burst_addr[1:0] = il ? (b[1:0] ^ c[1:0]) : (b[1:0] + c[1:0]);
    endfunction

    task automatic check(string name, logic [35:0] e, logic [35:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic results;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // one offer to the command stream; the model follows only accepted commands
    task automatic push_try(bit wr, bit adv, logic [18:0] a, logic [3:0] ln, output bit acc);
        logic [35:0] d;
        logic [18:0] wa;
        @(negedge clk_sys);
        rnd = lfsr(rnd);
        d[15:0] = rnd;
        rnd = lfsr(rnd);
        d[35:16] = {rnd[3:0] ^ rnd[7:4], rnd};
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_advance = adv;
        cmd_addr = a;
        cmd_lanes_n = ln;
        {cmd_parity, cmd_data} = d;
        // sleep drops a command in flight, so it is only raised on a quiet bus
        if (rnd_ctl) begin
            hold_req = rnd[0] & rnd[1];
        end
        // ready follows only the count, so it is settled here, before the edge
        acc = (cmd_ready === 1'b1);
        @(posedge clk_sys);
        if (acc) begin
            if (adv) begin
                cnt++;
            end else begin
                base = a;
                cnt = 0;
                rd_op = !wr;
            end
            wa = burst_addr(base, cnt, u_bus.burst_order_strap);
            if (rd_op) begin
                exp_q.push_back(mem_m[wa]);
            end else begin
                for (int l = 0; l < 4; l++) begin
                    if (!ln[l]) begin
                        mem_m[wa][8*l +: 8] = d[8*l +: 8];
                        mem_m[wa][32+l] = d[32+l];
                    end
                end
            end
        end
    endtask

    task automatic push(bit wr, bit adv, logic [18:0] a, logic [3:0] ln);
        bit acc;
        int k;
        k = 0;
        do begin
            push_try(wr, adv, a, ln, acc);
            k++;
        end while (!acc && k < 200);
    endtask

    task automatic idle(int c);
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        hold_req = 1'b0;
        sleep_req = 1'b0;
        repeat (c) @(negedge clk_sys);
    endtask

    // every returned read is held against the model, away from the launching edge
    always @(negedge clk_sys) begin
        if (!sys_rst && rd_valid_q === 1'b1) begin
            check("read", exp_q.size() > 0 ? exp_q.pop_front() : 'x, {rd_parity_q, rd_data_q});
        end
    end

    // hang guard, well above the few hundred cycles the run needs
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end

    initial begin
        u_bus.burst_order_strap = 1'b1;
        repeat (20) @(negedge clk_sys);
        sys_rst = 1'b0;
        for (int i = 0; i < 16; i++) push(1, 0, i, 4'h0);
        // random mix with lane masks and stretches
        rnd_ctl = 1;
        for (int i = 0; i < 80; i++) push(rnd[4], 0, {15'h0, rnd[9:6]}, rnd[13:10]);
        rnd_ctl = 0;
        // sleep once the buffer has drained; status shows sleeping and deselected
        idle(16);
        sleep_req = 1'b1;
        repeat (4) @(negedge clk_sys);
        check("sleeping", 36'(1), 36'(sleeping));
        check("selected", 36'(0), 36'(selected));
        for (int s = 0; s < 2; s++) begin
            idle(4);
            u_bus.burst_order_strap = s[0];
            idle(2);
            push(1, 0, 19'h100 + rnd[1:0], 4'h0);
            repeat (3) push(1, 1, 19'h0, 4'h0);
            push(0, 0, 19'h100 + rnd[3:2], 4'h0);
            repeat (3) push(0, 1, 19'h0, 4'h0);
            for (int i = 0; i < 4; i++) push(0, 0, 19'h100 + i, 4'h0);
        end
        // fill the buffer under a stall until it refuses
        idle(10);
        hold_req = 1'b1;
        n = 0;
        for (int i = 0; i < 9; i++) begin
            push_try(0, 0, i, 4'h0, ok);
            n += ok;
        end
        check("fill", 36'(8), 36'(n));
        idle(2);
        for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(negedge clk_sys);
        check("pending", '0, 36'(exp_q.size()));
        results();
    end
endmodule
